//--- core/status_system.sv
// Status event groups, status byte summary and service request
`timescale 1ns/1ps
module status_system (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Power-up configuration
   input wire logic power_on_clear_setting,
   input wire logic [7:0] saved_gen_enable,
   input wire logic [7:0] saved_sre,
   // Command port
   input wire logic cmd_valid,
   input wire status_pkg::cmd_type cmd,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   // Instrument events and conditions
   input wire status_pkg::event_in_type ev,
   input wire logic alarm_queue_not_empty,
   input wire logic commands_done,
   input wire logic scan_active,
   input wire logic message_available,
   input wire logic oper_summary,
   input wire logic serial_poll,
   // Error queue push
   output logic err_push,
   output status_pkg::err_kind_type err_kind,
   // Status outputs
   output logic [7:0] status_byte,
   output status_pkg::summary_type summary,
   output logic srq
);
   import status_pkg::*;

   // Places one flag at its weight in a 16-bit word
   function automatic logic [15:0] at16(input logic flag, input int pos);
      at16 = flag ? (16'h0001 << pos) : 16'h0000;
   endfunction

   // Places one flag at its weight in an 8-bit word
   function automatic logic [7:0] at8(input logic flag, input int pos);
      at8 = flag ? (8'h01 << pos) : 8'h00;
   endfunction

   // Command decode
   logic is_cls, is_preset, is_ques_evq, is_ques_enw, is_ques_enq, is_gen_evq, is_gen_enw, is_gen_enq;
   logic is_alarm_evq, is_alarm_condq, is_alarm_enw, is_alarm_enq, is_opc, is_sre_w, is_sre_q, is_stb_q, is_query;

   assign is_cls = cmd_valid && (cmd.code == CMD_CLEAR_STATUS);
   assign is_preset = cmd_valid && (cmd.code == CMD_PRESET);
   assign is_ques_evq = cmd_valid && (cmd.code == CMD_QUES_EVENT_QUERY);
   assign is_ques_enw = cmd_valid && (cmd.code == CMD_QUES_ENABLE_WRITE);
   assign is_ques_enq = cmd_valid && (cmd.code == CMD_QUES_ENABLE_QUERY);
   assign is_gen_evq = cmd_valid && (cmd.code == CMD_GEN_EVENT_QUERY);
   assign is_gen_enw = cmd_valid && (cmd.code == CMD_GEN_ENABLE_WRITE);
   assign is_gen_enq = cmd_valid && (cmd.code == CMD_GEN_ENABLE_QUERY);
   assign is_alarm_evq = cmd_valid && (cmd.code == CMD_ALARM_EVENT_QUERY);
   assign is_alarm_condq = cmd_valid && (cmd.code == CMD_ALARM_COND_QUERY);
   assign is_alarm_enw = cmd_valid && (cmd.code == CMD_ALARM_ENABLE_WRITE);
   assign is_alarm_enq = cmd_valid && (cmd.code == CMD_ALARM_ENABLE_QUERY);
   assign is_opc = cmd_valid && (cmd.code == CMD_OPC);
   assign is_sre_w = cmd_valid && (cmd.code == CMD_SRE_WRITE);
   assign is_sre_q = cmd_valid && (cmd.code == CMD_SRE_QUERY);
   assign is_stb_q = cmd_valid && (cmd.code == CMD_STB_QUERY);
   assign is_query = is_ques_evq | is_ques_enq | is_gen_evq | is_gen_enq | is_alarm_evq | is_alarm_condq
      | is_alarm_enq | is_sre_q | is_stb_q;

   // Power-up marker that survives one cycle past reset
   logic in_reset;

   always_ff @(posedge sys_clk)
   begin
      in_reset <= !rst_n;
   end

   logic powering;
   assign powering = in_reset && rst_n;

   // Measurement overload of any kind
   logic any_overload;
   assign any_overload = ev.volt_overload | ev.curr_overload | ev.res_overload | ev.temp_overload;

   // Quality group inputs
   logic [15:0] ques_set;
   assign ques_set = at16(ev.volt_overload, QUES_VOLT_BIT)
      | at16(ev.curr_overload, QUES_CURR_BIT)
      | at16(ev.res_overload, QUES_RES_BIT)
      | at16(ev.temp_overload, QUES_TEMP_BIT)
      | at16(ev.totalizer_overflow, QUES_TOTAL_BIT)
      | at16(ev.memory_lost, QUES_MEM_BIT);

   logic ques_clear, ques_en_clear;
   assign ques_clear = is_cls | is_ques_evq;
   assign ques_en_clear = powering | is_preset;

   logic [15:0] ques_events, ques_enable;
   logic ques_summary;

   event_group #(
      .W(QUES_W),
      .USED(QUES_USED),
      .EVENT_RESET(QUES_EVENT_RESET),
      .ENABLE_RESET(QUES_ENABLE_RESET)
   ) u_ques (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_bits(ques_set),
      .clear_events(ques_clear),
      .enable_write(is_ques_enw),
      .enable_value(cmd.value),
      .enable_clear(ques_en_clear),
      .events(ques_events),
      .enable(ques_enable),
      .summary(ques_summary)
   );

   // Operation complete tracking
   logic opc_done;

   opc_tracker u_opc (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .opc_mark(is_opc),
      .commands_done(commands_done),
      .scan_active(scan_active),
      .opc_done(opc_done)
   );

   // General group inputs
   logic query_err;
   assign query_err = ev.empty_read | ev.unread_query | ev.buffers_full;

   logic [7:0] gen_set;
   assign gen_set = at8(opc_done, GEN_OPC_BIT)
      | at8(query_err, GEN_QUERY_BIT)
      | at8(ev.device_error | any_overload, GEN_DEVICE_BIT)
      | at8(ev.exec_error, GEN_EXEC_BIT)
      | at8(ev.command_error, GEN_CMD_BIT);

   logic gen_clear;
   assign gen_clear = is_cls | is_gen_evq;

   // Mask is cleared or restored at power-up by the clear setting
   logic gen_en_write;
   logic [7:0] gen_en_value;
   assign gen_en_write = powering | is_gen_enw;
   assign gen_en_value = powering ? (power_on_clear_setting ? 8'h00 : saved_gen_enable) : cmd.value[7:0];

   logic [7:0] gen_events, gen_enable;
   logic gen_summary;

   // Power-on bit comes from the event reset value
   event_group #(
      .W(GEN_W),
      .USED(GEN_USED),
      .EVENT_RESET(GEN_EVENT_RESET),
      .ENABLE_RESET(GEN_ENABLE_RESET)
   ) u_gen (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_bits(gen_set),
      .clear_events(gen_clear),
      .enable_write(gen_en_write),
      .enable_value(gen_en_value),
      .enable_clear(1'b0),
      .events(gen_events),
      .enable(gen_enable),
      .summary(gen_summary)
   );

   // Alarm group inputs
   logic [15:0] alarm_set;
   assign alarm_set = ({12'h000, ev.alarm_hit} << ALARM_FIRST_BIT)
      | at16(ev.alarm_lost, ALARM_OVF_BIT);

   logic alarm_clear, alarm_en_clear;
   assign alarm_clear = is_cls | is_alarm_evq;
   assign alarm_en_clear = powering | is_preset;

   logic [15:0] alarm_events, alarm_enable;
   logic alarm_summary;

   event_group #(
      .W(ALARM_W),
      .USED(ALARM_USED),
      .EVENT_RESET(ALARM_EVENT_RESET),
      .ENABLE_RESET(ALARM_ENABLE_RESET)
   ) u_alarm (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .set_bits(alarm_set),
      .clear_events(alarm_clear),
      .enable_write(is_alarm_enw),
      .enable_value(cmd.value),
      .enable_clear(alarm_en_clear),
      .events(alarm_events),
      .enable(alarm_enable),
      .summary(alarm_summary)
   );

   // Alarm condition word, only the queue bit exists
   logic [15:0] alarm_cond;
   assign alarm_cond = at16(alarm_queue_not_empty, ALARM_QNE_BIT);

   // Error queue push for errors other than overloads
   err_kind_type next_err_kind;
   assign next_err_kind.query = query_err;
   assign next_err_kind.device = ev.device_error;
   assign next_err_kind.exec = ev.exec_error;
   assign next_err_kind.command = ev.command_error;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         err_push <= 1'b0;
         err_kind <= '0;
      end
      else
      begin
         err_push <= |next_err_kind;
         err_kind <= next_err_kind;
      end
   end

   // Status byte enable, set at power-up by the clear setting
   logic [7:0] sre;
   logic [7:0] next_sre;
   assign next_sre = powering ? (power_on_clear_setting ? 8'h00 : (saved_sre & STB_ENABLE_USED))
      : (is_sre_w ? (cmd.value[7:0] & STB_ENABLE_USED) : sre);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         sre <= SRE_RESET;
      else
         sre <= next_sre;
   end

   // Status byte condition bits without the request bit
   logic [7:0] stb_base;
   assign stb_base = at8(alarm_summary, STB_ALARM_BIT)
      | at8(ques_summary, STB_QUES_BIT)
      | at8(message_available, STB_MAV_BIT)
      | at8(gen_summary, STB_GEN_BIT)
      | at8(oper_summary, STB_OPER_BIT);

   // Master summary and request on its rising edge
   logic master;
   logic master_prev;
   logic rqs;
   logic next_rqs;
   assign master = |(stb_base & sre);
   assign next_rqs = (master & ~master_prev) | (rqs & ~serial_poll);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         master_prev <= 1'b0;
         rqs <= 1'b0;
      end
      else
      begin
         master_prev <= master;
         rqs <= next_rqs;
      end
   end

   // Query answer selection
   logic [15:0] next_rsp;
   assign next_rsp = is_ques_evq ? ques_events
      : is_ques_enq ? ques_enable
      : is_gen_evq ? {8'h00, gen_events}
      : is_gen_enq ? {8'h00, gen_enable}
      : is_alarm_evq ? alarm_events
      : is_alarm_condq ? alarm_cond
      : is_alarm_enq ? alarm_enable
      : is_sre_q ? {8'h00, sre}
      : is_stb_q ? {8'h00, stb_base | at8(master, STB_RQS_BIT)}
      : 16'h0000;

   // Registered answer and status outputs
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
         status_byte <= 8'h00;
         summary <= '0;
      end
      else
      begin
         rsp_valid <= is_query;
         rsp_data <= next_rsp;
         status_byte <= stb_base | at8(rqs, STB_RQS_BIT);
         summary <= {alarm_summary, ques_summary, gen_summary, master};
      end
   end

   assign srq = rqs;
endmodule

//--- core/status_pkg.sv
// Shared constants, types and commands for the status event register groups
// Operation
// - Enabled quality events OR into quality summary
// - Overload sets quality bit and general bit 3
// - Volt 1, current 2, resistance 512 quality weights
// - Temperature 1024, totalizer overflow 2048 quality weights
// - Memory full with lost reading sets 4096
// - Clear-status or quality query clears quality events
// - Quality mask cleared at power, preset, zero
// - Operation complete set when prior commands finish; code also waits until no scan is active
// - Query error weight 4 on three causes
// - Device 8, execution 16, command 32 errors
// - Error bits 2-5 push error entry, except overload
// - Power-on bit 128 set until read or cleared
// - General summary goes to status byte bit 5
// - Four alarm limits latch at weights 1-8
// - Alarm condition bit 4 shows queue not empty
// - Alarm queue discard sets weight 32
// - Clear-status or alarm query clears alarm events
// - Alarm mask cleared at power, preset, zero
// - Events latch and stay; repeats ignored
// - Service request on status bit 6 rising
// - Clear-status keeps masks, clears all events
package status_pkg;
   // Group widths
   localparam int QUES_W = 16;
   localparam int GEN_W = 8;
   localparam int ALARM_W = 16;
   // Quality group bit positions
   localparam int QUES_VOLT_BIT = 0;
   localparam int QUES_CURR_BIT = 1;
   localparam int QUES_RES_BIT = 9;
   localparam int QUES_TEMP_BIT = 10;
   localparam int QUES_TOTAL_BIT = 11;
   localparam int QUES_MEM_BIT = 12;
   localparam logic [15:0] QUES_USED = 16'h1e03;
   localparam logic [15:0] QUES_EVENT_RESET = 16'h0000;
   // General group bit positions
   localparam int GEN_OPC_BIT = 0;
   localparam int GEN_QUERY_BIT = 2;
   localparam int GEN_DEVICE_BIT = 3;
   localparam int GEN_EXEC_BIT = 4;
   localparam int GEN_CMD_BIT = 5;
   localparam int GEN_PON_BIT = 7;
   localparam logic [7:0] GEN_USED = 8'hbd;
   localparam logic [7:0] GEN_EVENT_RESET = 8'h80;
   // Alarm group bit positions
   localparam int ALARM_FIRST_BIT = 0;
   localparam int ALARM_COUNT = 4;
   localparam int ALARM_QNE_BIT = 4;
   localparam int ALARM_OVF_BIT = 5;
   localparam logic [15:0] ALARM_USED = 16'h002f;
   localparam logic [15:0] ALARM_EVENT_RESET = 16'h0000;
   // Status byte bit positions
   localparam int STB_ALARM_BIT = 1;
   localparam int STB_QUES_BIT = 3;
   localparam int STB_MAV_BIT = 4;
   localparam int STB_GEN_BIT = 5;
   localparam int STB_RQS_BIT = 6;
   localparam int STB_OPER_BIT = 7;
   localparam logic [7:0] STB_ENABLE_USED = 8'hba;
   // Enable reset values
   localparam logic [15:0] QUES_ENABLE_RESET = 16'h0000;
   localparam logic [7:0] GEN_ENABLE_RESET = 8'h00;
   localparam logic [15:0] ALARM_ENABLE_RESET = 16'h0000;
   localparam logic [7:0] SRE_RESET = 8'h00;

   // Commands from the remote command parser
   typedef enum logic [3:0] {
      CMD_CLEAR_STATUS = 4'h0,
      CMD_PRESET = 4'h1,
      CMD_QUES_EVENT_QUERY = 4'h2,
      CMD_QUES_ENABLE_WRITE = 4'h3,
      CMD_QUES_ENABLE_QUERY = 4'h4,
      CMD_GEN_EVENT_QUERY = 4'h5,
      CMD_GEN_ENABLE_WRITE = 4'h6,
      CMD_GEN_ENABLE_QUERY = 4'h7,
      CMD_ALARM_EVENT_QUERY = 4'h8,
      CMD_ALARM_COND_QUERY = 4'h9,
      CMD_ALARM_ENABLE_WRITE = 4'ha,
      CMD_ALARM_ENABLE_QUERY = 4'hb,
      CMD_OPC = 4'hc,
      CMD_SRE_WRITE = 4'hd,
      CMD_SRE_QUERY = 4'he,
      CMD_STB_QUERY = 4'hf
   } cmd_code_type;

   typedef struct packed {
      cmd_code_type code;
      logic [15:0] value;
   } cmd_type;

   // Raw instrument event strobes, one cycle each
   typedef struct packed {
      logic volt_overload;
      logic curr_overload;
      logic res_overload;
      logic temp_overload;
      logic totalizer_overflow;
      logic memory_lost;
      logic empty_read;
      logic unread_query;
      logic buffers_full;
      logic device_error;
      logic exec_error;
      logic command_error;
      logic [3:0] alarm_hit;
      logic alarm_lost;
   } event_in_type;

   // Error queue push classes
   typedef struct packed {
      logic query;
      logic device;
      logic exec;
      logic command;
   } err_kind_type;

   // Group summaries
   typedef struct packed {
      logic alarm;
      logic ques;
      logic gen;
      logic master;
   } summary_type;
endpackage

//--- core/event_group.sv
// One latched event register with its enable mask and summary
`timescale 1ns/1ps
module event_group #(
   parameter int W = 16,
   parameter logic [W-1:0] USED = '1,
   parameter logic [W-1:0] EVENT_RESET = '0,
   parameter logic [W-1:0] ENABLE_RESET = '0
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Event side
   input wire logic [W-1:0] set_bits,
   input wire logic clear_events,
   // Mask side
   input wire logic enable_write,
   input wire logic [W-1:0] enable_value,
   input wire logic enable_clear,
   // Results
   output logic [W-1:0] events,
   output logic [W-1:0] enable,
   output logic summary
);
   logic [W-1:0] next_events;
   logic [W-1:0] next_enable;

   // Set wins over clear; unused bits never latch
   assign next_events = ((clear_events ? '0 : events) | set_bits) & USED;
   // Zero write or enable_clear clears the mask; clear wins over a write
   assign next_enable = enable_clear ? '0 : (enable_write ? (enable_value & USED) : enable);
   // Summary from currently latched events
   assign summary = |(events & enable);

   // Event and mask registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         events <= EVENT_RESET;
         enable <= ENABLE_RESET;
      end
      else
      begin
         events <= next_events;
         enable <= next_enable;
      end
   end
endmodule

//--- core/opc_tracker.sv
// Holds a pending operation-complete mark until commands and scan finish
`timescale 1ns/1ps
module opc_tracker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Mark and completion conditions
   input wire logic opc_mark,
   input wire logic commands_done,
   input wire logic scan_active,
   // Completion pulse
   output logic opc_done
);
   logic pending;
   logic finish;
   logic next_pending;

   // Completion needs idle parser and no scan
   assign finish = pending && commands_done && !scan_active;
   // A new mark in the finishing cycle stays pending
   assign next_pending = opc_mark | (pending & ~finish);

   // Pending flag and one-cycle done pulse
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pending <= 1'b0;
         opc_done <= 1'b0;
      end
      else
      begin
         pending <= next_pending;
         opc_done <= finish;
      end
   end
endmodule

//--- dv/status_system_monitor.sv
// Port checker for the status system
`timescale 1ns/1ps
module status_system_monitor
   import status_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Inputs
   input wire logic cmd_valid,
   input wire status_pkg::cmd_type cmd,
   input wire status_pkg::event_in_type ev,
   input wire logic alarm_queue_not_empty,
   input wire logic serial_poll,
   // Outputs
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data,
   input wire logic err_push,
   input wire status_pkg::err_kind_type err_kind,
   input wire logic [7:0] status_byte,
   input wire status_pkg::summary_type summary,
   input wire logic srq
);
   // Command and strobe classes
   wire logic is_query = cmd_valid && (cmd.code inside {4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hb, 4'he, 4'hf});
   wire logic narrow_query = cmd_valid && (cmd.code inside {4'h5, 4'h7, 4'he, 4'hf});
   wire logic query_err = ev.empty_read || ev.unread_query || ev.buffers_full;
   wire logic any_err = query_err || ev.device_error || ev.exec_error || ev.command_error;
   wire logic any_ovl = ev.volt_overload || ev.curr_overload || ev.res_overload || ev.temp_overload;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Error strobe followed by its queue entry
   sequence s_err_strobe;
      any_err;
   endsequence
   sequence s_err_entry;
      err_push && err_kind.query == $past(query_err) && err_kind.device == $past(ev.device_error)
         && err_kind.exec == $past(ev.exec_error) && err_kind.command == $past(ev.command_error);
   endsequence

   a_query_answer: assert property (rsp_valid == $past(is_query))
      else $error("answer pulse does not follow a query");
   a_cond_answer: assert property (cmd_valid && cmd.code == CMD_ALARM_COND_QUERY |=>
      rsp_data == {11'h000, $past(alarm_queue_not_empty), 4'h0}) else $error("alarm condition answer wrong");
   a_narrow_answer: assert property (narrow_query |=> rsp_data[15:8] == 8'h00)
      else $error("byte answer has upper bits");
   a_ques_unused: assert property (cmd_valid && cmd.code == CMD_QUES_EVENT_QUERY |=>
      (rsp_data & ~QUES_USED) == 16'h0000) else $error("quality unused bit set");
   a_alarm_unused: assert property (cmd_valid && cmd.code == CMD_ALARM_EVENT_QUERY |=>
      (rsp_data & ~ALARM_USED) == 16'h0000) else $error("alarm unused bit set");
   a_overload_silent: assert property (any_ovl && !any_err |=> !err_push)
      else $error("overload pushed an error entry");
   a_error_entry: assert property (s_err_strobe |=> s_err_entry)
      else $error("error entry missing or wrong kind");
   a_srq_cause: assert property ($rose(srq) |-> summary.master)
      else $error("request without master summary");
   a_poll_clears: assert property (serial_poll && summary.master |=> !srq)
      else $error("serial poll left request set");
   a_srq_holds: assert property (srq && !serial_poll |=> srq)
      else $error("request dropped without poll");
   a_stb_unused: assert property (!status_byte[0] && !status_byte[2])
      else $error("status byte unused bit set");
endmodule

bind status_system status_system_monitor status_system_monitor_inst (.sys_clk, .rst_n, .cmd_valid, .cmd, .ev,
   .alarm_queue_not_empty, .serial_poll, .rsp_valid, .rsp_data, .err_push, .err_kind, .status_byte, .summary, .srq);

//--- dv/host_model.sv
// Host controller model on the command port
`timescale 1ns/1ps
module host_model
   import status_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Command port
   output status_pkg::cmd_type cmd,
   output logic cmd_valid,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data,
   // Polled status
   input wire logic [7:0] status_byte
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd = '{CMD_STB_QUERY, 16'h0000};
   end
   // One command; payload scrambled once released
   task automatic send(input cmd_code_type code, input logic [15:0] value);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd <= '{code, value};
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      cmd.value <= ~value;
   endtask
   // Answer is registered one cycle after the command
   task automatic query(input cmd_code_type code, output logic [15:0] data, output logic seen);
      send(code, 16'h0000);
      #1;
      seen = rsp_valid;
      data = rsp_data;
   endtask
   // Completion setup: clear, enable bit 0, sync, then mark
   task automatic start_completion;
      logic [15:0] d;
      logic s;
      send(CMD_CLEAR_STATUS, 16'h0000);
      send(CMD_GEN_ENABLE_WRITE, 16'h0001);
      send(CMD_SRE_WRITE, 16'h0020);
      query(CMD_STB_QUERY, d, s);
      send(CMD_OPC, 16'h0000);
   endtask
   // Poll status byte bit 5 with a bound
   task automatic poll_bit5(input int limit, output logic done);
      done = 1'b0;
      for (int i = 0; i < limit && !done; i++)
      begin
         @(posedge sys_clk);
         #1;
         done = status_byte[5];
      end
   endtask
endmodule

//--- dv/status_system_tb.sv
// Self-checking testbench of the status system
`timescale 1ns/1ps
module status_system_tb;
   import status_pkg::*;
   logic sys_clk, rst_n, power_on_clear_setting, cmd_valid, rsp_valid, alarm_queue_not_empty;
   logic commands_done, scan_active, serial_poll, err_push, srq;
   logic [7:0] saved_gen_enable, saved_sre, status_byte;
   cmd_type cmd;
   logic [15:0] rsp_data;
   event_in_type ev;
   err_kind_type err_kind;
   summary_type summary;
   int err_count = 0, tests_run = 0, cycles = 0;
   // Expected weights, strobe i is event bit 16-i
   logic [15:0] exp_ques [17] = '{0: 16'h1, 1: 16'h2, 2: 16'h200, 3: 16'h400, 4: 16'h800, 5: 16'h1000,
      default: 16'h0};
   logic [15:0] exp_gen [17] = '{16'h8, 16'h8, 16'h8, 16'h8, 16'h0, 16'h0, 16'h4, 16'h4, 16'h4, 16'h8,
      16'h10, 16'h20, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [15:0] exp_alarm [17] = '{12: 16'h8, 13: 16'h4, 14: 16'h2, 15: 16'h1, 16: 16'h20, default: 16'h0};

   status_system status_system_inst (.sys_clk, .rst_n, .power_on_clear_setting, .saved_gen_enable, .saved_sre,
      .cmd_valid, .cmd, .rsp_valid, .rsp_data, .ev, .alarm_queue_not_empty, .commands_done, .scan_active,
      .message_available(1'b0), .oper_summary(1'b0), .serial_poll, .err_push, .err_kind, .status_byte,
      .summary, .srq);
   host_model host_model_inst (.sys_clk, .cmd, .cmd_valid, .rsp_valid, .rsp_data, .status_byte);

   // Clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Cycle ceiling against a hung run
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         give_verdict;
      end
   end

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic give_verdict;
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic expect_query(input string name, input cmd_code_type code, input logic [15:0] exp);
      logic [15:0] d;
      logic s;
      host_model_inst.query(code, d, s);
      check({name, " valid"}, 16'h0001, 16'(s));
      check(name, exp, d);
   endtask
   task automatic pulse(input event_in_type e);
      @(posedge sys_clk);
      ev <= e;
      @(posedge sys_clk);
      ev <= '0;
   endtask
   task automatic do_reset(input logic setting);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      power_on_clear_setting <= setting;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask

   // Power-up mask handling for one setting of the clear flag
   task automatic t_power_up(input logic setting);
      host_model_inst.send(CMD_QUES_ENABLE_WRITE, 16'hffff);
      host_model_inst.send(CMD_ALARM_ENABLE_WRITE, 16'hffff);
      do_reset(setting);
      expect_query("gen events", CMD_GEN_EVENT_QUERY, 16'h0080);
      expect_query("gen reread", CMD_GEN_EVENT_QUERY, 16'h0000);
      expect_query("gen enable", CMD_GEN_ENABLE_QUERY, setting ? 16'h0000 : 16'h003c);
      expect_query("sre", CMD_SRE_QUERY, setting ? 16'h0000 : 16'h00ba);
      expect_query("ques enable", CMD_QUES_ENABLE_QUERY, 16'h0000);
      expect_query("alarm enable", CMD_ALARM_ENABLE_QUERY, 16'h0000);
   endtask
   // Each doubled strobe lands once; query clears
   task automatic t_event_weights;
      for (int i = 0; i < 17; i++)
      begin
         pulse(event_in_type'(17'h10000 >> i));
         pulse(event_in_type'(17'h10000 >> i));
         expect_query("ques events", CMD_QUES_EVENT_QUERY, exp_ques[i]);
         expect_query("gen events", CMD_GEN_EVENT_QUERY, exp_gen[i]);
         expect_query("alarm events", CMD_ALARM_EVENT_QUERY, exp_alarm[i]);
         expect_query("ques cleared", CMD_QUES_EVENT_QUERY, 16'h0000);
         expect_query("gen cleared", CMD_GEN_EVENT_QUERY, 16'h0000);
         expect_query("alarm cleared", CMD_ALARM_EVENT_QUERY, 16'h0000);
      end
      @(posedge sys_clk);
      alarm_queue_not_empty <= 1'b1;
      expect_query("alarm cond", CMD_ALARM_COND_QUERY, 16'h0010);
      @(posedge sys_clk);
      alarm_queue_not_empty <= 1'b0;
      expect_query("alarm cond empty", CMD_ALARM_COND_QUERY, 16'h0000);
   endtask
   // Mask keep, preset, zero write, late enable
   task automatic t_masks;
      host_model_inst.send(CMD_QUES_ENABLE_WRITE, 16'hffff);
      host_model_inst.send(CMD_GEN_ENABLE_WRITE, 16'hffff);
      host_model_inst.send(CMD_ALARM_ENABLE_WRITE, 16'hffff);
      pulse(event_in_type'(17'h10042));
      host_model_inst.send(CMD_CLEAR_STATUS, 16'h0000);
      expect_query("ques after clear", CMD_QUES_EVENT_QUERY, 16'h0000);
      expect_query("gen after clear", CMD_GEN_EVENT_QUERY, 16'h0000);
      expect_query("alarm after clear", CMD_ALARM_EVENT_QUERY, 16'h0000);
      expect_query("ques mask kept", CMD_QUES_ENABLE_QUERY, 16'h1e03);
      expect_query("gen mask kept", CMD_GEN_ENABLE_QUERY, 16'h00bd);
      expect_query("alarm mask kept", CMD_ALARM_ENABLE_QUERY, 16'h002f);
      host_model_inst.send(CMD_PRESET, 16'h0000);
      expect_query("ques mask preset", CMD_QUES_ENABLE_QUERY, 16'h0000);
      expect_query("alarm mask preset", CMD_ALARM_ENABLE_QUERY, 16'h0000);
      host_model_inst.send(CMD_GEN_ENABLE_WRITE, 16'h0000);
      expect_query("gen mask zero", CMD_GEN_ENABLE_QUERY, 16'h0000);
      pulse(event_in_type'(17'h10000));
      host_model_inst.send(CMD_QUES_ENABLE_WRITE, 16'h0002);
      repeat (2) @(posedge sys_clk);
      #1;
      check("ques summary off", 16'h0000, 16'(summary.ques));
      host_model_inst.send(CMD_QUES_ENABLE_WRITE, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #1;
      check("ques summary on", 16'h0001, 16'(summary.ques));
      check("stb ques bit", 16'h0001, 16'(status_byte[3]));
      host_model_inst.send(CMD_QUES_ENABLE_WRITE, 16'h0000);
      expect_query("ques mask zero", CMD_QUES_ENABLE_QUERY, 16'h0000);
   endtask
   // Completion held off by pending commands and a running scan
   task automatic t_opc;
      logic done;
      @(posedge sys_clk);
      commands_done <= 1'b0;
      scan_active <= 1'b1;
      host_model_inst.start_completion;
      repeat (6) @(posedge sys_clk);
      commands_done <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      check("bit 5 in scan", 16'h0000, 16'(status_byte[5]));
      @(posedge sys_clk);
      scan_active <= 1'b0;
      host_model_inst.poll_bit5(20, done);
      check("completion seen", 16'h0001, 16'(done));
      repeat (3) @(posedge sys_clk);
      #1;
      check("srq raised", 16'h0001, 16'(srq));
      @(posedge sys_clk);
      serial_poll <= 1'b1;
      @(posedge sys_clk);
      serial_poll <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      check("srq polled", 16'h0000, 16'(srq));
      expect_query("opc bit", CMD_GEN_EVENT_QUERY, 16'h0001);
   endtask

   initial
   begin
      rst_n = 1'b0;
      power_on_clear_setting = 1'b0;
      saved_gen_enable = 8'h3c;
      saved_sre = 8'hff;
      ev = '0;
      alarm_queue_not_empty = 1'b0;
      commands_done = 1'b1;
      scan_active = 1'b0;
      serial_poll = 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_power_up(1'b0);
      t_power_up(1'b1);
      t_event_weights;
      t_masks;
      t_opc;
      give_verdict;
   end
endmodule
